// ===== bench/mmd_cpu_model.sv
/*
 CPU-side model: drives code fetch, data requests and password words.
 Assumes the decoder samples its inputs on the rising edge of i_ref_clk.
*/
module mmd_cpu_model (
   // Clock
   input wire logic i_ref_clk,
   // Requests towards the decoder
   output mmd_pkg::mmd_req_t o_fetch,
   output mmd_pkg::mmd_req_t o_data,
   output mmd_pkg::mmd_unlock_t o_unlock
);
   timeunit 1ns;
   timeprecision 1ps;
   import mmd_pkg::*;
   initial begin
      o_fetch = '0;
      o_data = '0;
      o_unlock = '0;
   end
   // Idle paths show an inverted address so stale values never look valid
   task automatic issue(input mmd_req_t f, input mmd_req_t d);
      @(posedge i_ref_clk);
      o_fetch <= f.valid ? f : {1'b0, ~o_fetch[26:0]};
      o_data <= d.valid ? d : {1'b0, ~o_data[26:0]};
   endtask : issue
   // High half first, then low half
   task automatic send_password(input logic [31:0] pw);
      @(posedge i_ref_clk);
      o_unlock <= '{valid: 1'b1, word: pw[31:16]};
      @(posedge i_ref_clk);
      o_unlock <= '{valid: 1'b1, word: pw[15:0]};
      @(posedge i_ref_clk);
      o_unlock <= '{valid: 1'b0, word: ~pw[15:0]};
   endtask : send_password
endmodule : mmd_cpu_model

// ===== bench/test_memory_map_decoder.sv
/*
 Self-checking bench for the memory map decoder.
 Assumes the CPU model drives requests and routes appear one edge later.
*/
module test_memory_map_decoder;
   timeunit 1ns;
   timeprecision 1ps;
   import mmd_pkg::*;
   localparam logic [31:0] PW = 32'h5a3c_c3a5;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [4:0] wp_kb = 5'h00;
   logic rd_prot = 1'b0;
   logic [19:0] sect_wp = 20'h00000;
   logic relock = 1'b0;
   mmd_req_t fetch;
   mmd_req_t data;
   mmd_unlock_t unlock;
   mmd_route_t fr;
   mmd_route_t dr;
   logic open;
   int errors = 0;
   int samples_checked = 0;
   always #4 clk = ~clk;
   mmd_cpu_model u_cpu (.i_ref_clk(clk), .o_fetch(fetch), .o_data(data), .o_unlock(unlock));
   mmd_decoder u_dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_fetch(fetch), .i_data(data),
      .i_program_sram_wp_kb(wp_kb), .i_flash_rd_protect(rd_prot), .i_sector_wp(sect_wp),
      .i_password(PW), .i_unlock(unlock), .i_relock(relock),
      .o_fetch_route(fr), .o_data_route(dr), .o_flash_open(open));
   task automatic conclude();
      $display("checked %0d, errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : conclude
   task automatic chk_bit(input string n, input logic e, input logic g);
      samples_checked++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED %s exp %b got %b", n, e, g);
      end
   endtask : chk_bit
   task automatic chk_vec(input string n, input logic [23:0] e, input logic [23:0] g);
      samples_checked++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask : chk_vec
   task automatic chk_rg(input string n, input mmd_region_t e, input mmd_region_t g);
      samples_checked++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED %s exp %s got %s", n, e.name(), g.name());
      end
   endtask : chk_rg
   function automatic mmd_req_t rq(input logic v, input logic w, input logic g, input logic [23:0] a);
      return '{valid: v, write: w, word: a[0], general_purpose_register: g, addr: a};
   endfunction : rq
   // One cycle of fetch and data, then wait for the registered routes
   task automatic acc(input mmd_req_t f, input mmd_req_t d);
      u_cpu.issue(f, d);
      @(posedge clk);
      #1;
   endtask : acc
   task automatic t_map();
      logic [23:0] a [16] = '{24'h00a010, 24'h00dfff, 24'h00e000, 24'h00f000, 24'h00f600, 24'h00fe00,
         24'h000000, 24'h010000, 24'h210000, 24'h400000, 24'hbfffff, 24'hc00000, 24'hc0f000,
         24'hc40000, 24'he80000, 24'hffff00};
      mmd_region_t r [16] = '{mmd_rg_data_sram, mmd_rg_data_sram, mmd_rg_extra_function_space, mmd_rg_extended_function_space, mmd_rg_dual_port_ram,
         mmd_rg_sfr, mmd_rg_ext, mmd_rg_ext, mmd_rg_ext_io, mmd_rg_ext, mmd_rg_ext, mmd_rg_flash0,
         mmd_rg_flash_sys, mmd_rg_flash1, mmd_rg_emulated_program_sram, mmd_rg_imb};
      for (int i = 0; i < 16; i++) begin
         acc(rq(1'b1, 1'b0, 1'b0, a[i]), rq(1'b1, 1'b0, 1'b0, a[i]));
         chk_rg("region", r[i], dr.region);
         chk_vec("seg_page", {a[i][23:14], 14'h0}, {dr.seg, dr.page, 14'h0});
         chk_bit("word", a[i][0], dr.word);
         chk_bit("denied", a[i] == 24'hc0f000, dr.denied);
         chk_bit("ext_bus", r[i] inside {mmd_rg_ext, mmd_rg_ext_io}, dr.ext_bus);
         chk_bit("no_pipe_opt", r[i] == mmd_rg_ext_io, dr.no_pipe_opt);
         chk_bit("fetch_no_pipe_opt", r[i] == mmd_rg_ext_io, fr.no_pipe_opt);
         chk_bit("fetch_denied", r[i] inside {mmd_rg_data_sram, mmd_rg_extra_function_space, mmd_rg_extended_function_space, mmd_rg_dual_port_ram, mmd_rg_sfr,
            mmd_rg_imb, mmd_rg_flash_sys}, fr.denied);
      end
      acc(rq(1'b0, 1'b0, 1'b0, 24'h0), rq(1'b1, 1'b1, 1'b0, 24'h204000));
      chk_rg("serial", mmd_rg_lpb, dr.region);
      chk_bit("serial_sysbus", 1'b1, dr.sysbus);
      acc(rq(1'b0, 1'b0, 1'b0, 24'h0), rq(1'b1, 1'b0, 1'b0, 24'hf00000));
      chk_rg("reserved", mmd_rg_rsvd, dr.region);
      chk_bit("reserved_ext", 1'b1, dr.ext_bus);
   endtask : t_map
   task automatic t_program_sram();
      @(posedge clk);
      wp_kb <= 5'h02;
      acc(rq(1'b1, 1'b1, 1'b0, 24'he00000), rq(1'b1, 1'b1, 1'b0, 24'he007fe));
      chk_bit("fetch_pmu", 1'b1, fr.program_memory_unit);
      chk_bit("fetch_write", 1'b0, fr.write);
      chk_bit("data_write", 1'b1, dr.write);
      chk_bit("wp_low", 1'b1, dr.denied);
      acc(rq(1'b0, 1'b0, 1'b0, 24'h0), rq(1'b1, 1'b1, 1'b0, 24'he00800));
      chk_bit("wp_high", 1'b0, dr.denied);
      acc(rq(1'b0, 1'b0, 1'b0, 24'h0), rq(1'b1, 1'b1, 1'b0, 24'he44401));
      chk_rg("mirror", mmd_rg_program_sram, dr.region);
      chk_vec("mirror_addr", 24'he00401, dr.addr);
      chk_bit("mirror_wp", 1'b1, dr.denied);
   endtask : t_program_sram
   task automatic t_flash();
      @(posedge clk);
      rd_prot <= 1'b1;
      sect_wp <= 20'hfffff;
      acc(rq(1'b0, 1'b0, 1'b0, 24'h0), rq(1'b1, 1'b0, 1'b0, 24'hc01234));
      chk_bit("rd_locked", 1'b1, dr.denied);
      chk_bit("ecc", 1'b1, dr.ecc_en);
      chk_vec("line", {4'h0, 20'hc0123}, {4'h0, dr.line});
      u_cpu.send_password(PW);
      #1;
      chk_bit("open", 1'b1, open);
      acc(rq(1'b0, 1'b0, 1'b0, 24'h0), rq(1'b1, 1'b0, 1'b0, 24'hc01234));
      chk_bit("rd_open", 1'b0, dr.denied);
      @(posedge clk);
      relock <= 1'b1;
      @(posedge clk);
      relock <= 1'b0;
      @(posedge clk);
      #1;
      chk_bit("relocked", 1'b0, open);
      @(posedge clk);
      rd_prot <= 1'b0;
   endtask : t_flash
   task automatic t_conc();
      acc(rq(1'b1, 1'b0, 1'b0, 24'hc00000), rq(1'b1, 1'b0, 1'b0, 24'hc00010));
      chk_bit("same_stall", 1'b1, dr.stall);
      chk_bit("fetch_wins", 1'b0, fr.stall);
      acc(rq(1'b1, 1'b0, 1'b0, 24'hc00000), rq(1'b1, 1'b0, 1'b0, 24'hc40000));
      chk_bit("diff_stall", 1'b0, dr.stall);
      acc(rq(1'b1, 1'b0, 1'b0, 24'he00000), rq(1'b1, 1'b1, 1'b0, 24'he00800));
      chk_bit("both_valid", 1'b1, fr.valid & dr.valid);
      chk_bit("both_ok", 1'b0, fr.denied | dr.denied);
      acc(rq(1'b1, 1'b0, 1'b0, 24'h00a000), rq(1'b0, 1'b0, 1'b0, 24'h0));
      chk_bit("fetch_data_sram", 1'b1, fr.denied);
   endtask : t_conc
   task automatic t_bit();
      logic [23:0] a [4] = '{24'h00f600, 24'h00fd00, 24'h00f600, 24'h00fe00};
      logic [3:0] g = 4'b0100;
      logic [3:0] e = 4'b1110;
      for (int i = 0; i < 4; i++) begin
         // Dual-port RAM and SFR accesses here are reads only
         acc(rq(1'b0, 1'b0, 1'b0, 24'h0), rq(1'b1, 1'b0, g[i], a[i]));
         chk_bit("bit_addr", e[i], dr.bit_addr);
      end
   endtask : t_bit
   initial begin
      #(20000 * 8);
      errors++;
      conclude();
   end
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      chk_bit("reset_valid", 1'b0, dr.valid);
      @(posedge clk);
      t_map();
      t_program_sram();
      t_flash();
      t_conc();
      t_bit();
      conclude();
   end
endmodule : test_memory_map_decoder

// ===== rtl/mmd_decoder.sv
/*
 Memory map decoder: routes code fetches and data accesses to their region.
 Assumes requests are synchronous to i_ref_clk; answers appear one clock later.
*/
`include "mmd_defines.svh"
module mmd_decoder #(
   parameter bit HAS_EXT_BUS = 1'b1,
   parameter int SECT_GRP_LOG2 = 2
) (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   // Requests
   input wire mmd_pkg::mmd_req_t i_fetch,
   input wire mmd_pkg::mmd_req_t i_data,
   // Protection
   input wire logic [4:0] i_program_sram_wp_kb,
   input wire logic i_flash_rd_protect,
   input wire logic [((64 >> SECT_GRP_LOG2) + (16 >> SECT_GRP_LOG2))-1:0] i_sector_wp,
   input wire logic [31:0] i_password,
   input wire mmd_pkg::mmd_unlock_t i_unlock,
   input wire logic i_relock,
   // Routes
   output mmd_pkg::mmd_route_t o_fetch_route,
   output mmd_pkg::mmd_route_t o_data_route,
   output logic o_flash_open
);
   import mmd_pkg::*;
   localparam int NG = (64 >> SECT_GRP_LOG2) + (16 >> SECT_GRP_LOG2);

   mmd_pw_t pw_reg, pw_next;
   mmd_route_t fetch_reg, fetch_next, data_reg, data_next;
   mmd_region_t data_rg, fetch_rg;
   logic open_reg, open_next;

   // Priority chain, highest base address first
   function automatic mmd_region_t decode(input logic [23:0] a);
      if (a >= `MMD_IMB_LO) decode = mmd_rg_imb;
      else if (a >= `MMD_RSV_TOP_LO) decode = mmd_rg_rsvd;
      else if (a >= `MMD_EPS_LO) decode = mmd_rg_emulated_program_sram;
      else if (a >= `MMD_PS_LO) decode = mmd_rg_program_sram;
      else if (a >= `MMD_FL_RSV_LO) decode = mmd_rg_rsvd;
      else if (a >= `MMD_FL1_LO) decode = mmd_rg_flash1;
      else if (a >= `MMD_FLS_LO && a <= `MMD_FLS_HI) decode = mmd_rg_flash_sys;
      else if (a >= `MMD_FL0_LO) decode = mmd_rg_flash0;
      else if (a >= `MMD_EXT_LO) decode = mmd_rg_ext;
      else if (a >= `MMD_EXTIO_LO) decode = mmd_rg_ext_io;
      else if (a >= `MMD_LPB_RSV_LO) decode = mmd_rg_rsvd;
      else if (a >= `MMD_LPB_ALT_LO) decode = mmd_rg_lpb;
      else if (a >= `MMD_LPB_GAP_LO) decode = mmd_rg_rsvd;
      else if (a >= `MMD_LPB_LO) decode = mmd_rg_lpb;
      else if (a >= `MMD_EXT1_LO) decode = mmd_rg_ext;
      else if (a >= `MMD_SFR_LO) decode = mmd_rg_sfr;
      else if (a >= `MMD_DPR_LO) decode = mmd_rg_dual_port_ram;
      else if (a >= `MMD_DPR_RSV_LO) decode = mmd_rg_rsvd;
      else if (a >= `MMD_EXTENDED_FUNCTION_SPACE_LO) decode = mmd_rg_extended_function_space;
      else if (a >= `MMD_EXTRA_FUNCTION_SPACE_LO) decode = mmd_rg_extra_function_space;
      else if (a >= `MMD_DS_LO) decode = mmd_rg_data_sram;
      else if (a >= `MMD_DS_RSV_LO) decode = mmd_rg_rsvd;
      else decode = mmd_rg_ext;
   endfunction : decode

   function automatic logic is_flash(input mmd_region_t g);
      is_flash = (g == mmd_rg_flash0) || (g == mmd_rg_flash1);
   endfunction : is_flash

   function automatic mmd_route_t route(input mmd_req_t q, input logic fetch, input logic locked,
                                        input logic [NG-1:0] wp, input logic [4:0] ps_wp);
      mmd_route_t r;
      mmd_region_t g;
      logic [7:0] sect;
      logic [7:0] grp;
      r = '0;
      g = decode(q.addr);
      sect = (g == mmd_rg_flash1) ? (`MMD_FL0_SECTORS + {4'h0, q.addr[15:12]}) : {2'b00, q.addr[17:12]};
      grp = sect >> SECT_GRP_LOG2;
      r.valid = q.valid;
      r.region = g;
      r.seg = q.addr[23:16];
      r.page = q.addr[15:14];
      r.word = q.word;
      r.write = q.write & ~fetch;
      r.addr = q.addr;
      if (g == mmd_rg_program_sram || g == mmd_rg_emulated_program_sram) begin
         r.addr[18:14] = 5'h00;
      end
      r.line = q.addr[23:4];
      r.ecc_en = is_flash(g);
      r.program_memory_unit = is_flash(g) || g == mmd_rg_flash_sys || g == mmd_rg_program_sram || g == mmd_rg_emulated_program_sram;
      r.ext_bus = g == mmd_rg_ext || g == mmd_rg_ext_io || g == mmd_rg_lpb
                  || (g == mmd_rg_rsvd && HAS_EXT_BUS);
      r.sysbus = fetch ? r.ext_bus : (r.program_memory_unit || r.ext_bus);
      r.no_pipe_opt = g == mmd_rg_ext_io;
      r.bit_addr = !fetch && (g == mmd_rg_sfr || g == mmd_rg_extended_function_space
                   || (g == mmd_rg_dual_port_ram && (q.general_purpose_register || q.addr[15:8] == `MMD_DPR_BIT_PAGE)));
      if (g == mmd_rg_flash_sys) begin
         r.denied = 1'b1;
      end else if (g == mmd_rg_rsvd && !HAS_EXT_BUS) begin
         r.denied = 1'b1;
      end else if (fetch && !r.program_memory_unit && !r.ext_bus) begin
         r.denied = 1'b1;
      end else if (is_flash(g) && !r.write && locked) begin
         r.denied = 1'b1;
      end else if (is_flash(g) && r.write && (locked || wp[grp[4:0]])) begin
         r.denied = 1'b1;
      end else if (g == mmd_rg_program_sram && r.write && {1'b0, q.addr[13:10]} < ps_wp) begin
         r.denied = 1'b1;
      end
      return r;
   endfunction : route

   assign data_rg = decode(i_data.addr);
   assign fetch_rg = decode(i_fetch.addr);

   // Password sequence: high half then low half
   always_comb begin
      pw_next = pw_reg;
      if (i_relock) begin
         pw_next = mmd_pw_idle;
      end else if (i_unlock.valid) begin
         case (pw_reg)
            mmd_pw_idle: pw_next = (i_unlock.word == i_password[31:16]) ? mmd_pw_half : mmd_pw_idle;
            mmd_pw_half: pw_next = (i_unlock.word == i_password[15:0]) ? mmd_pw_open : mmd_pw_idle;
            default: pw_next = pw_reg;
         endcase
      end
      open_next = pw_next == mmd_pw_open;
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         pw_reg <= mmd_pw_idle;
         open_reg <= 1'b0;
      end else begin
         pw_reg <= pw_next;
         open_reg <= open_next;
      end
   end

   // Both paths decoded every cycle; same flash module stalls the data side
   always_comb begin
      logic locked;
      logic [NG-1:0] wp;
      locked = i_flash_rd_protect && pw_reg != mmd_pw_open;
      wp = pw_reg == mmd_pw_open ? '0 : i_sector_wp;
      fetch_next = route(i_fetch, 1'b1, locked, wp, i_program_sram_wp_kb);
      data_next = route(i_data, 1'b0, locked, wp, i_program_sram_wp_kb);
      data_next.stall = i_fetch.valid && i_data.valid && is_flash(data_rg)
                        && data_rg == fetch_rg;
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         fetch_reg <= '0;
         data_reg <= '0;
      end else begin
         fetch_reg <= fetch_next;
         data_reg <= data_next;
      end
   end

   assign o_fetch_route = fetch_reg;
   assign o_data_route = data_reg;
   assign o_flash_open = open_reg;

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);

   property p_data_region;
      i_data.valid |=> o_data_route.valid && o_data_route.region == $past(data_rg);
   endproperty
   a_data_region: assert property (p_data_region) else $error("data region mismatch");

   property p_sys_sector;
      i_data.valid && data_rg == mmd_rg_flash_sys |=> o_data_route.denied;
   endproperty
   a_sys_sector: assert property (p_sys_sector) else $error("system sector not denied");

   property p_ext_win;
      i_data.valid && i_data.addr >= `MMD_EXT_LO && i_data.addr <= `MMD_EXT_HI
      |=> o_data_route.ext_bus && o_data_route.sysbus && !o_data_route.denied;
   endproperty
   a_ext_win: assert property (p_ext_win) else $error("external window not forwarded");

   property p_ext_io;
      i_fetch.valid && i_fetch.addr >= `MMD_EXTIO_LO && i_fetch.addr <= `MMD_EXTIO_HI
      |=> o_fetch_route.no_pipe_opt && o_fetch_route.ext_bus;
   endproperty
   a_ext_io: assert property (p_ext_io) else $error("external io flag missing");

   property p_program_sram_wp;
      i_data.valid && i_data.write && data_rg == mmd_rg_program_sram
      && {1'b0, i_data.addr[13:10]} < i_program_sram_wp_kb |=> o_data_route.denied;
   endproperty
   a_program_sram_wp: assert property (p_program_sram_wp) else $error("protected sram write passed");

   sequence s_unlock;
      (i_unlock.valid && !i_relock && pw_reg == mmd_pw_idle && i_unlock.word == i_password[31:16])
      ##1 (i_unlock.valid && !i_relock && i_unlock.word == i_password[15:0]);
   endsequence
   property p_unlock;
      s_unlock |=> o_flash_open ##1 (o_flash_open || $past(i_relock));
   endproperty
   a_unlock: assert property (p_unlock) else $error("password did not open flash");

   property p_flash_par;
      i_fetch.valid && i_data.valid && fetch_rg == mmd_rg_flash0 && data_rg == mmd_rg_flash1
      |=> !o_data_route.stall && o_fetch_route.valid && o_data_route.valid;
   endproperty
   a_flash_par: assert property (p_flash_par) else $error("parallel flash access stalled");

   property p_fetch_pmu;
      i_fetch.valid && fetch_rg == mmd_rg_program_sram |=> o_fetch_route.program_memory_unit && !o_fetch_route.sysbus;
   endproperty
   a_fetch_pmu: assert property (p_fetch_pmu) else $error("fetch not via program unit");

   property p_data_sram;
      i_data.valid && i_data.addr >= `MMD_DS_LO && i_data.addr <= `MMD_DS_HI
      |=> o_data_route.region == mmd_rg_data_sram && !o_data_route.sysbus && !o_data_route.program_memory_unit;
   endproperty
   a_data_sram: assert property (p_data_sram) else $error("data sram path wrong");

   property p_serial;
      i_data.valid && i_data.addr >= `MMD_SER_LO && i_data.addr <= `MMD_SER_HI
      |=> o_data_route.region == mmd_rg_lpb && o_data_route.sysbus;
   endproperty
   a_serial: assert property (p_serial) else $error("serial registers not via system bus");

   property p_seg_page;
      i_data.valid |=> o_data_route.seg == $past(i_data.addr[23:16])
      && o_data_route.page == $past(i_data.addr[15:14]);
   endproperty
   a_seg_page: assert property (p_seg_page) else $error("segment or page field wrong");

   // Byte or word size travels with every access
   property p_word;
      i_data.valid |=> o_data_route.word == $past(i_data.word);
   endproperty
   a_word: assert property (p_word) else $error("access size lost");

   // A fetch never becomes a write, whatever the request carries
   property p_fetch_ro;
      i_fetch.valid |=> o_fetch_route.valid && !o_fetch_route.write;
   endproperty
   a_fetch_ro: assert property (p_fetch_ro) else $error("fetch routed as write");

   // Data-only regions are out of reach of the program path
   property p_fetch_data_rg;
      i_fetch.valid && fetch_rg inside {mmd_rg_data_sram, mmd_rg_extra_function_space, mmd_rg_extended_function_space, mmd_rg_dual_port_ram, mmd_rg_sfr}
      |=> o_fetch_route.denied && !o_fetch_route.program_memory_unit;
   endproperty
   a_fetch_data_rg: assert property (p_fetch_data_rg) else $error("fetch reached data region");

   property p_rsvd_ext;
      i_data.valid && data_rg == mmd_rg_rsvd
      |=> o_data_route.ext_bus == HAS_EXT_BUS && o_data_route.denied == !HAS_EXT_BUS;
   endproperty
   a_rsvd_ext: assert property (p_rsvd_ext) else $error("reserved access not external");

   property p_ecc;
      i_data.valid && data_rg inside {mmd_rg_flash0, mmd_rg_flash1}
      |=> o_data_route.ecc_en && o_data_route.line == $past(i_data.addr[23:4]);
   endproperty
   a_ecc: assert property (p_ecc) else $error("flash line or correction missing");

   // Whole mirror window folds onto the one physical program SRAM
   property p_mirror;
      i_data.valid && i_data.addr >= `MMD_PS_LO && i_data.addr < `MMD_EPS_LO
      |=> o_data_route.region == mmd_rg_program_sram && o_data_route.addr[18:14] == 5'h00 && o_data_route.program_memory_unit;
   endproperty
   a_mirror: assert property (p_mirror) else $error("program sram mirror not folded");

   property p_bit_page;
      i_data.valid && !i_data.general_purpose_register && data_rg == mmd_rg_dual_port_ram
      |=> o_data_route.bit_addr == ($past(i_data.addr[15:8]) == `MMD_DPR_BIT_PAGE);
   endproperty
   a_bit_page: assert property (p_bit_page) else $error("dual-port bit page wrong");

   // Relock beats any password word in the same cycle
   property p_relock;
      i_relock |=> !o_flash_open;
   endproperty
   a_relock: assert property (p_relock) else $error("relock left flash open");

   property p_same_flash;
      i_fetch.valid && i_data.valid && fetch_rg == mmd_rg_flash0 && data_rg == mmd_rg_flash0
      |=> o_data_route.stall && !o_fetch_route.stall;
   endproperty
   a_same_flash: assert property (p_same_flash) else $error("same flash module not arbitrated");

   property p_cov_stall;
      i_fetch.valid && i_data.valid && fetch_rg == mmd_rg_flash0 && data_rg == mmd_rg_flash0;
   endproperty
   c_stall: cover property (p_cov_stall);

   property p_cov_unlock;
      s_unlock;
   endproperty
   c_unlock: cover property (p_cov_unlock);

   property p_cov_rsvd;
      i_data.valid && data_rg == mmd_rg_rsvd;
   endproperty
   c_rsvd: cover property (p_cov_rsvd);

   property p_cov_open;
      $rose(o_flash_open);
   endproperty
   c_open: cover property (p_cov_open);

   property p_cov_mirror;
      i_data.valid && i_data.write && data_rg == mmd_rg_program_sram && i_data.addr[18:14] != 5'h00;
   endproperty
   c_mirror: cover property (p_cov_mirror);

endmodule : mmd_decoder

// ===== rtl/mmd_defines.svh
/*
 Address map constants for the memory map decoder.
 Assumes inclusion by the decoder.
*/
`ifndef MMD_DEFINES_SVH
`define MMD_DEFINES_SVH
`define MMD_IMB_LO 24'hffff00
`define MMD_RSV_TOP_LO 24'hf00000
`define MMD_EPS_LO 24'he80000
`define MMD_PS_LO 24'he00000
`define MMD_FL_RSV_LO 24'hc50000
`define MMD_FL1_LO 24'hc40000
`define MMD_FLS_LO 24'hc0f000
`define MMD_FLS_HI 24'hc0ffff
`define MMD_FL0_LO 24'hc00000
`define MMD_EXT_LO 24'h400000
`define MMD_EXT_HI 24'hbfffff
`define MMD_EXTIO_LO 24'h210000
`define MMD_EXTIO_HI 24'h3fffff
`define MMD_LPB_RSV_LO 24'h20bc00
`define MMD_LPB_ALT_LO 24'h208000
`define MMD_LPB_GAP_LO 24'h205800
`define MMD_SER_LO 24'h204000
`define MMD_SER_HI 24'h2057ff
`define MMD_LPB_LO 24'h200000
`define MMD_EXT1_LO 24'h010000
`define MMD_SFR_LO 24'h00fe00
`define MMD_DPR_LO 24'h00f600
`define MMD_DPR_BIT_PAGE 8'hfd
`define MMD_DPR_RSV_LO 24'h00f200
`define MMD_EXTENDED_FUNCTION_SPACE_LO 24'h00f000
`define MMD_EXTRA_FUNCTION_SPACE_LO 24'h00e000
`define MMD_DS_LO 24'h00a000
`define MMD_DS_HI 24'h00dfff
`define MMD_DS_RSV_LO 24'h008000
`define MMD_FL0_SECTORS 8'h40
`define MMD_FL1_SECTORS 8'h10
`endif

// ===== rtl/mmd_pkg.sv
/*
 Types for the memory map decoder.
 Assumes the defines header sits beside it.
*/
package mmd_pkg;
   typedef enum logic [3:0] {
      mmd_rg_ext, mmd_rg_ext_io, mmd_rg_lpb, mmd_rg_flash0, mmd_rg_flash1, mmd_rg_flash_sys,
      mmd_rg_program_sram, mmd_rg_emulated_program_sram, mmd_rg_data_sram, mmd_rg_extra_function_space, mmd_rg_extended_function_space, mmd_rg_dual_port_ram,
      mmd_rg_sfr, mmd_rg_imb, mmd_rg_rsvd
   } mmd_region_t;
   typedef enum logic [1:0] {mmd_pw_idle, mmd_pw_half, mmd_pw_open} mmd_pw_t;
   typedef struct packed {
      logic valid;
      logic write;
      logic word;
      logic general_purpose_register;
      logic [23:0] addr;
   } mmd_req_t;
   typedef struct packed {
      logic valid;
      logic [15:0] word;
   } mmd_unlock_t;
   typedef struct packed {
      logic valid;
      mmd_region_t region;
      logic program_memory_unit;
      logic sysbus;
      logic ext_bus;
      logic no_pipe_opt;
      logic bit_addr;
      logic denied;
      logic stall;
      logic ecc_en;
      logic word;
      logic write;
      logic [7:0] seg;
      logic [1:0] page;
      logic [23:0] addr;
      logic [19:0] line;
   } mmd_route_t;
endpackage : mmd_pkg
